// File: verilog/adc_seq_regs.svh
// register map, field positions and timing constants of the sample/convert sequencer
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define CTRL_OFS          12'h000
`define SAMPLE_OFS        12'h004
`define TIMING_OFS        12'h008
`define STATUS_OFS        12'h00c
`define PERIOD_OFS        12'h010

`define CTRL_ON_BIT       0
`define CTRL_AUTO_BIT     1
`define CTRL_SIM_BIT      2
`define CTRL_EDGE_BIT     3
`define CTRL_TRIG_LSB     4
`define CTRL_CH_LSB       8
`define SAMPLE_BIT        0
`define DONE_BIT          1
`define SAMPLE_CNT_LSB    0
`define CONV_LSB          8

`define TRIG_MANUAL       3'h0
`define TRIG_EXT_PIN      3'h1
`define TRIG_TIMER        3'h2
`define TRIG_PWM          3'h3
`define TRIG_CLOCKED      3'h7

`define CONV_CLKS_RST     5'h0c
`define SAMPLE_CNT_RST    5'h01
`define PERIOD_RST        32'hffff_ffff

`endif

// File: verilog/adc_seq_pkg.sv
// types shared by the sample/convert sequencer
package adc_seq_pkg;

  typedef struct packed {
    logic [2:0] conv_trigger_select;
    logic       auto_sample_enable;
    logic       simultaneous_sample_select;
    logic [1:0] channel_count_select;
    logic       ext_edge_falling;
    logic       module_on;
  } seq_cfg_t;

  typedef struct packed {
    logic [3:0] sampling;
    logic [3:0] converting;
    logic [1:0] channel;
  } hold_ctl_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CHSAMP = 4'b0100,
    ST_CONV   = 4'b1000
  } seq_state_t;

endpackage : adc_seq_pkg

// File: verilog/adc_pin_sync.sv
// two-stage synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module adc_pin_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // pin and edge choice
  input  wire logic pin_async,
  input  wire logic falling_sel,
  // detected edge
  output logic      edge_pulse
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  wire  rise_w = sync_r & ~last_r;
  wire  fall_w = ~sync_r & last_r;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign edge_pulse = falling_sel ? fall_w : rise_w;
endmodule : adc_pin_sync

// File: verilog/adc_timer_match.sv
// 32-bit timer pair that raises a trigger pulse on a period match
`timescale 1ns/1ps
module adc_timer_match (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // control
  input  wire logic        run,
  input  wire logic [31:0] period_pair_32,
  // match
  output logic             match_pulse
);
  logic [31:0] timer_pair_32_r;
  wire         hit_w = run & (timer_pair_32_r == period_pair_32);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timer_pair_32_r <= 32'h0000_0000;
      match_pulse     <= 1'b0;
    end else begin
      timer_pair_32_r <= !run ? 32'h0000_0000 :
                         hit_w ? 32'h0000_0000 : timer_pair_32_r + 32'h0000_0001;
      match_pulse     <= hit_w;
    end
  end
endmodule : adc_timer_match

// File: verilog/adc_sample_convert_sequencer.sv
// sample/convert sequencer with clocked and event conversion triggers
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

// Contract
// - selector 111 plus auto: endless back-to-back sequences
// - clocked manual: sample bit starts, count ends
// - clocked auto simultaneous: resample all after last
// - single/simultaneous sample time is count times clock
// - clocked sequential: own sample interval per channel
// - sequence lasts channels times sample plus convert; simultaneous mode: one sample, then channels times convert
// - selector 001: chosen pin edge starts conversion
// - selector 010: 32-bit period match triggers
// - selector 011: PWM special event triggers
// - event plus auto: one conversion per trigger
// - event simultaneous: sample all until trigger
// - event sequential: channel samples until its conversion; later channels stop at the trigger instead
// - selector 000: clearing sample bit converts
// - done sets at sequence end, sample clears
module adc_sample_convert_sequencer
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // trigger sources
  input  wire logic                    ext_interrupt_pin_zero,
  input  wire logic                    pwm_special_event,
  // sample/hold and converter control
  output adc_seq_pkg::hold_ctl_t       hold_ctl,
  output logic                         sequence_done
);
  import adc_seq_pkg::*;

  seq_cfg_t   cfg_r;
  logic [4:0] sample_clock_count_r;
  logic [4:0] conv_clks_r;
  logic [31:0] period_pair_32_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [1:0] chan_r;
  logic [1:0] chan_nxt;
  logic       sample_active_r;
  logic       done_r;
  logic       pwm_r;
  logic       ext_edge;
  logic       tmr_match;

  // apb decode
  wire acc_w   = psel & penable;
  wire wr_w    = acc_w & pwrite;
  wire hit_ctl = paddr == `CTRL_OFS;
  wire hit_smp = paddr == `SAMPLE_OFS;
  wire hit_tim = paddr == `TIMING_OFS;
  wire hit_sts = paddr == `STATUS_OFS;
  wire hit_per = paddr == `PERIOD_OFS;
  wire mapped  = hit_ctl | hit_smp | hit_tim | hit_sts | hit_per;
  wire wr_ctl  = wr_w & hit_ctl;
  wire wr_smp  = wr_w & hit_smp;
  wire wr_tim  = wr_w & hit_tim;
  wire wr_per  = wr_w & hit_per;

  wire set_sample_active = wr_smp & pwdata[`SAMPLE_BIT];
  wire clr_sample_active = wr_smp & ~pwdata[`SAMPLE_BIT];

  wire on_w     = cfg_r.module_on;
  wire clocked  = cfg_r.conv_trigger_select == `TRIG_CLOCKED;
  wire manual   = cfg_r.conv_trigger_select == `TRIG_MANUAL;
  wire sim_w    = cfg_r.simultaneous_sample_select;
  wire [1:0] last_ch = cfg_r.channel_count_select[1] ? 2'h3 :
                       cfg_r.channel_count_select[0] ? 2'h1 : 2'h0;
  wire seq_w    = ~sim_w & (last_ch != 2'h0);

  wire sel_pin  = cfg_r.conv_trigger_select == `TRIG_EXT_PIN;
  wire sel_tmr  = cfg_r.conv_trigger_select == `TRIG_TIMER;
  wire sel_pwm  = cfg_r.conv_trigger_select == `TRIG_PWM;
  // only the selected source can end sampling
  wire ev_trig  = (sel_pin & ext_edge) |
                  (sel_tmr & tmr_match) |
                  (sel_pwm & pwm_r);
  wire manual_end = manual & clr_sample_active;
  // counts start at zero, so the last sample clock is count minus one
  wire sample_active_full  = cnt_r + 5'h01 >= sample_clock_count_r;
  // zero count in sequential mode: next conversion follows at once
  wire skip_sample_active  = sample_clock_count_r == 5'h00;
  wire conv_full  = cnt_r + 5'h01 >= conv_clks_r;
  wire is_last    = chan_r == last_ch;
  wire restart    = cfg_r.auto_sample_enable;

  adc_pin_sync u_pin_sync (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .pin_async   (ext_interrupt_pin_zero),
    .falling_sel (cfg_r.ext_edge_falling),
    .edge_pulse  (ext_edge)
  );

  // counter runs only while the timer source is selected
  adc_timer_match u_timer (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .run            (on_w & sel_tmr),
    .period_pair_32 (period_pair_32_r),
    .match_pulse    (tmr_match)
  );

  // sequence state machine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 5'h01;
    chan_nxt  = chan_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt  = 5'h00;
        chan_nxt = 2'h0;
        if (on_w && (set_sample_active || restart)) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // shared interval; in sequential mode later channels stop sampling when it ends
        if ((clocked && sample_active_full) || ev_trig || manual_end) begin
          state_nxt = ST_CONV;
          cnt_nxt   = 5'h00;
        end
      end
      ST_CHSAMP: begin
        // clocked sequential: own interval before this channel's conversion
        if (sample_active_full) begin
          state_nxt = ST_CONV;
          cnt_nxt   = 5'h00;
        end
      end
      ST_CONV: begin
        if (conv_full) begin
          cnt_nxt = 5'h00;
          if (!is_last) begin
            chan_nxt  = chan_r + 2'h1;
            state_nxt = (seq_w && clocked && !skip_sample_active) ? ST_CHSAMP : ST_CONV;
          end else begin
            chan_nxt  = 2'h0;
            state_nxt = restart ? ST_SAMPLE : ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!on_w) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 5'h00;
      chan_nxt  = 2'h0;
    end
  end

  // done only for a completed sequence, never after a switch-off
  wire seq_end = (state_r == ST_CONV) & conv_full & is_last & on_w;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 5'h00;
      chan_r  <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      chan_r  <= chan_nxt;
    end
  end

  // pwm event is on this clock: one register, no synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_special_event;
    end
  end

  // control register; trigger select only changes while off
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cfg_r <= '0;
    end else if (wr_ctl) begin
      cfg_r.module_on                  <= pwdata[`CTRL_ON_BIT];
      cfg_r.auto_sample_enable         <= pwdata[`CTRL_AUTO_BIT];
      cfg_r.simultaneous_sample_select <= pwdata[`CTRL_SIM_BIT];
      cfg_r.ext_edge_falling           <= pwdata[`CTRL_EDGE_BIT];
      cfg_r.channel_count_select       <= pwdata[`CTRL_CH_LSB +: 2];
      if (!cfg_r.module_on) begin
        cfg_r.conv_trigger_select <= pwdata[`CTRL_TRIG_LSB +: 3];
      end
    end
  end

  // timing and timer period registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sample_clock_count_r <= `SAMPLE_CNT_RST;
      conv_clks_r          <= `CONV_CLKS_RST;
      period_pair_32_r     <= `PERIOD_RST;
    end else begin
      if (wr_tim) begin
        sample_clock_count_r <= pwdata[`SAMPLE_CNT_LSB +: 5];
        conv_clks_r          <= pwdata[`CONV_LSB +: 5];
      end
      if (wr_per) begin
        period_pair_32_r <= pwdata;
      end
    end
  end

  // status: sample bit clears at end of sampling, done sets at sequence end
  wire sample_active_nxt = (state_nxt == ST_SAMPLE) | (state_nxt == ST_CHSAMP);
  wire seq_start = (state_r == ST_IDLE) & (state_nxt == ST_SAMPLE);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sample_active_r <= 1'b0;
      done_r          <= 1'b0;
    end else begin
      sample_active_r <= sample_active_nxt;
      if (seq_end) begin
        done_r <= 1'b1;
      end else if (set_sample_active || seq_start) begin
        done_r <= 1'b0;
      end
    end
  end

  // per-channel sample/hold and converter strobes
  logic [3:0] sample_active_w;
  logic [3:0] conv_w;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      // channels above the count stay idle
      wire en_w = (2'(g) <= last_ch);
      wire own  = chan_nxt == 2'(g);
      wire done_ch = 2'(g) < chan_nxt;
      assign conv_w[g] = en_w & own & (state_nxt == ST_CONV);
      // simultaneous: all sample together; sequential: shared interval, own interval, with auto again after own conversion
      assign sample_active_w[g] = en_w & (sim_w ? (state_nxt == ST_SAMPLE) :
                         (own ? sample_active_nxt : (state_nxt != ST_IDLE) &
                          (done_ch ? restart : (state_nxt == ST_SAMPLE))));
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hold_ctl      <= '0;
      sequence_done <= 1'b0;
    end else begin
      hold_ctl.sampling   <= sample_active_w;
      hold_ctl.converting <= conv_w;
      hold_ctl.channel    <= chan_nxt;
      sequence_done       <= seq_end;
    end
  end

  // apb read and answer
  wire [31:0] ctrl_word = {20'h00000, 2'h0, cfg_r.channel_count_select, 1'b0,
                           cfg_r.conv_trigger_select, cfg_r.ext_edge_falling,
                           cfg_r.simultaneous_sample_select,
                           cfg_r.auto_sample_enable, cfg_r.module_on};
  wire [31:0] stat_word = {30'h0000_0000, done_r, sample_active_r};
  wire [31:0] tim_word  = {19'h00000, conv_clks_r, 3'h0, sample_clock_count_r};
  wire [31:0] rd_w      = hit_ctl ? ctrl_word :
                          hit_smp | hit_sts ? stat_word :
                          hit_tim ? tim_word :
                          hit_per ? period_pair_32_r : 32'h0000_0000;
  // zero wait: the answer stands in the access cycle only
  wire        setup_w   = psel & ~penable;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & ~mapped;
      prdata  <= (setup_w & ~pwrite) ? rd_w : 32'h0000_0000;
    end
  end
endmodule : adc_sample_convert_sequencer

// File: test/adc_seq_assertions.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module adc_seq_assertions
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rstn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // sequencer outputs
  input wire adc_seq_pkg::hold_ctl_t hold_ctl,
  input wire logic                   sequence_done
);
  import adc_seq_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdata; !pready |-> prdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside access");
  property p_excl; (hold_ctl.sampling & hold_ctl.converting) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("channel samples and converts");
  property p_chan; |hold_ctl.converting |-> hold_ctl.converting == 4'h1 << hold_ctl.channel;
  endproperty
  a_chan: assert property (p_chan) else $error("converting channel mismatch");
  property p_done1; sequence_done |=> !sequence_done; endproperty
  a_done1: assert property (p_done1) else $error("done longer than a cycle");
  property p_donecv;
    sequence_done |-> $past(hold_ctl.converting) != 4'h0 || $past(hold_ctl.converting, 2) != 4'h0;
  endproperty
  a_donecv: assert property (p_donecv) else $error("done without conversion");
  property p_rst; $rose(rstn) |-> hold_ctl == '0 && !sequence_done; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  c_done: cover property (sequence_done);
  c_all: cover property (hold_ctl.sampling == 4'hf);
  c_err: cover property (pslverr);
endmodule : adc_seq_assertions

bind adc_sample_convert_sequencer adc_seq_assertions u_chk (.sys_clk, .rstn, .psel,
  .penable, .prdata, .pready, .pslverr, .hold_ctl, .sequence_done);

// File: test/adc_trig_src.sv
// trigger sources at the far side: pin and pwm event
`timescale 1ns/1ps
module adc_trig_src (
  // clock
  input  wire logic sys_clk,
  // trigger outputs
  output logic      pin,
  output logic      pwm_evt
);
  initial begin
    pin = 1'b0;
    pwm_evt = 1'b0;
  end
  // pin level; edge choice is made by the bench
  task automatic set_pin(input logic v);
    @(posedge sys_clk);
    pin <= v;
  endtask : set_pin
  // one-cycle special event
  task automatic fire_pwm();
    @(posedge sys_clk);
    pwm_evt <= 1'b1;
    @(posedge sys_clk);
    pwm_evt <= 1'b0;
  endtask : fire_pwm
endmodule : adc_trig_src

// File: test/tb_adc_sample_convert_sequencer.sv
// self-checking bench of the sample/convert sequencer
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module tb_adc_sample_convert_sequencer;
  import adc_seq_pkg::*;
  logic sys_clk, rstn, psel, penable, pwrite, re, pin, pwm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq, st;
  logic pready, pslverr, sequence_done;
  hold_ctl_t hold_ctl;
  int num_errors, checks_done, dones, n, s, d0, sc, cc, p;
  adc_sample_convert_sequencer u_dut (.sys_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_interrupt_pin_zero(pin),
    .pwm_special_event(pwm), .hold_ctl, .sequence_done);
  adc_trig_src u_src (.sys_clk, .pin, .pwm_evt(pwm));
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (sequence_done === 1'b1) dones++;
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin @(posedge sys_clk); end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc
  // cycles to next done, with sampling cycles of channel 0
  task automatic wait_done();
    n = 0;
    s = 0;
    do begin
      @(negedge sys_clk);
      n++;
      s += (hold_ctl.sampling[0] === 1'b1);
    end while (sequence_done !== 1'b1 && n < 3000);
    if (sequence_done !== 1'b1) num_errors++;
  endtask : wait_done
  task automatic cfg(input logic [31:0] v);
    apb(1, `CTRL_OFS, v & 32'h3fe);
    apb(1, `CTRL_OFS, v);
  endtask : cfg
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #6000000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    st = 32'h17d8;
    cyc(12);
    rstn <= 1'b1;
    apb(0, `TIMING_OFS, 0);
    chk(rq, 32'h0c01);
    apb(0, `PERIOD_OFS, 0);
    chk(rq, `PERIOD_RST);
    apb(0, 12'h020, 0);
    chk({31'h0, re}, 32'h1);
    chk(rq, 32'h0);
    $display("test regs done");
    sc = 1 + xs() % 6;
    cc = 2 + xs() % 4;
    apb(1, `TIMING_OFS, (cc << 8) | sc);
    cfg(32'h073);
    apb(0, `CTRL_OFS, 0);
    chk(rq, 32'h073);
    wait_done();
    wait_done();
    chk(n, sc + cc);
    chk(s, sc);
    cfg(32'h273);
    wait_done();
    wait_done();
    chk(n, 4 * (sc + cc));
    chk(s, 4 * (sc + cc) - cc);
    cfg(32'h277);
    wait_done();
    wait_done();
    chk(n, sc + 4 * cc);
    chk(s, sc);
    $display("test clocked done");
    cfg(32'h071);
    apb(1, `SAMPLE_OFS, 1);
    wait_done();
    chk(n <= sc + cc + 4, 1);
    apb(0, `STATUS_OFS, 0);
    chk(rq, 32'h2);
    d0 = dones;
    cyc(40);
    chk(dones, d0);
    cfg(32'h001);
    apb(1, `SAMPLE_OFS, 1);
    cyc(20);
    chk(dones, d0);
    apb(1, `SAMPLE_OFS, 0);
    wait_done();
    chk(n < cc + 8, 1);
    $display("test manual done");
    cfg(32'h013);
    cyc(10);
    d0 = dones;
    u_src.fire_pwm();
    cyc(30);
    chk(dones, d0);
    u_src.set_pin(1);
    wait_done();
    chk(n < cc + 10, 1);
    cfg(32'h01b);
    cyc(30);
    d0 = dones;
    u_src.set_pin(0);
    wait_done();
    chk(n < cc + 10, 1);
    cyc(1);
    chk(dones, d0 + 1);
    cfg(32'h033);
    d0 = dones;
    repeat (3) begin
      u_src.fire_pwm();
      cyc(sc + 4 * cc + 10);
    end
    chk(dones, d0 + 3);
    cfg(32'h237);
    cyc(5);
    chk({28'h0, hold_ctl.sampling}, 32'hf);
    u_src.fire_pwm();
    wait_done();
    chk(n, 4 * cc + 2);
    chk(s, n - 4 * cc);
    cfg(32'h233);
    cyc(5);
    u_src.fire_pwm();
    wait_done();
    chk(n, 4 * cc + 2);
    chk(s, n - cc);
    $display("test event done");
    p = 40 + xs() % 20;
    apb(1, `PERIOD_OFS, p);
    cfg(32'h023);
    wait_done();
    wait_done();
    d0 = n;
    wait_done();
    chk(n, d0);
    chk(n, p + 1);
    chk(n > cc, 1);
    $display("test timer done");
    report_and_stop();
  end
endmodule : tb_adc_sample_convert_sequencer
